// ===== src/fpc_pkg.sv
`default_nettype none
package fpc_pkg;
    // special function address of the flash control register
    localparam logic [7:0] FLASH_CONTROL_ADDR  = 8'hd1;
    localparam logic [7:0] FLASH_CONTROL_RESET = 8'h00;
    // field positions inside the flash control register
    localparam int CMD_HI   = 7;
    localparam int CMD_LO   = 4;
    localparam int MAP_BIT  = 3;
    localparam int MODE_HI  = 2;
    localparam int MODE_LO  = 1;
    localparam int BUSY_BIT = 0;
    // launch command nibbles
    localparam logic [3:0] CMD_ARM  = 4'h5;
    localparam logic [3:0] CMD_FIRE = 4'ha;
    // code read windows
    localparam logic [15:0] EXTRA_ROW_SPACE_BASE = 16'hff80;
    localparam logic [15:0] SEC_ADDR  = 16'h0000;
    localparam logic [15:0] LATCH_SEC = 16'h0000;
    // security byte: lock bits 2..0, zero means programmed
    localparam logic [7:0] SEC_BYTE_RESET = 8'hfb;
    localparam logic [7:0] LOCK_MASK      = 8'h07;
    localparam int         LB0_POS        = 0;
    localparam int         LB1_POS        = 1;
    localparam int         LB2_POS        = 2;
    localparam logic [7:0] BARRED_BYTE    = 8'hff;
    // extra row and column latch geometry
    localparam int EXTRA_ROW_SPACE_DEPTH = 128;
    // programming time
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_NS  = 10000;
    localparam int PROG_CYCLES   =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // targeted flash space
    typedef enum logic [1:0] {
        SPACE_USER     = 2'b00,
        SPACE_EXTRA_ROW_SPACE     = 2'b01,
        SPACE_SECURITY = 2'b10,
        SPACE_NONE     = 2'b11
    } fpc_space_t;
    // where the executing code sits
    localparam logic [1:0] FROM_USER     = 2'b00;
    localparam logic [1:0] FROM_BOOT     = 2'b01;
    localparam logic [1:0] FROM_EXTERNAL = 2'b11;
    // launch sequencer, gray along idle, armed, wait
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_ARMED = 2'b01,
        SEQ_WAIT  = 2'b11
    } fpc_seq_t;
endpackage
`default_nettype wire

// ===== src/fpc_byte_mem.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_byte_mem
    import fpc_pkg::*;
#(
    parameter int DEPTH = EXTRA_ROW_SPACE_DEPTH,
    parameter int WIDTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk_i,
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    // storage has no reset, like the flash cells it stands for
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    // registered read, one cycle of latency
    always_ff @(posedge clk_i) begin
        rd_data_o <= mem_reg[rd_addr_i];
    end
endmodule
`default_nettype wire

// ===== src/fpc_prog_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_prog_timer
    import fpc_pkg::*;
#(
    parameter int CYCLES = PROG_CYCLES,
    parameter int CW     = $clog2(CYCLES + 1)
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          start_i,
    output logic               busy_o,
    output logic               done_o,
    output logic      [CW-1:0] step_o
);
    // counts the steps of one programming cycle; restart ignored when busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            step_o <= '0;
        end else begin
            done_o <= 1'b0;
            if (!busy_o && start_i) begin
                busy_o <= 1'b1;
                step_o <= '0;
            end else if (busy_o) begin
                if (step_o == CW'(CYCLES - 1)) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                step_o <= step_o + CW'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/fpc_flash_control.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE1 - software writes 0Ch to map latch and security space before loading
// RULE2 - software keeps interrupts off through a security byte programming
// RULE3 - software stages the security byte by xdata write at address 0000h
// RULE4 - command pair 54h then A4h, from boot flash, programs the security byte
// RULE5 - busy flag drops when the launched programming finishes
// RULE6 - user code read by indexed code read; control held cleared otherwise
// RULE7 - writing 02h maps extra row at index zero, pointer FF80h to FFFFh
// RULE8 - writing zero unmaps extra row or security byte, normal user reads
// RULE9 - writing 04h maps security space; index zero, pointer zero reads it
// RULE10 - mode field 10 targets the security byte for reads and programming
// RULE11 - three lock bits, parallel mode writes only, default level four
// RULE12 - level one: external code reads return internal bytes uncoded
// RULE13 - level two: external reads barred, access pin latched, parallel writes off
// RULE14 - level three adds blocked parallel verification
// RULE15 - level four adds blocked rollover execution beyond 7FFFh
// RULE16 - software programs levels two and three only after verification
// RULE17 - register at D1h: nibble 7-4, map bit 3, mode 2-1, busy bit 0
// RULE18 - upper nibble 5 then A launches programming of the selected space
// RULE19 - map bit set steers xdata accesses to the column latch
// RULE20 - boot flash code may program user, eeprom, security byte, extra row; no eeprom space exists here
// RULE21 - external or rollover code gets no internal flash access
// RULE22 - busy flag stands set for the whole programming operation
// RULE23 - the two launch writes must be consecutive, else programming aborts
// RULE24 - command pair 50h then A0h, from boot flash, programs user space
// RULE25 - a lone launch write starts nothing and leaves busy cleared
module fpc_flash_control
    import fpc_pkg::*;
#(
    parameter int PROG_CNT = PROG_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic        instr_start_i,
    input  wire logic [1:0]  fetch_region_i,
    input  wire logic        rollover_i,
    input  wire logic        code_rd_i,
    input  wire logic [7:0]  code_acc_i,
    input  wire logic [15:0] code_data_pointer_i,
    input  wire logic [7:0]  user_byte_i,
    output logic      [7:0]  code_rdata_o,
    output logic             code_valid_o,
    input  wire logic        xdata_wr_i,
    input  wire logic        xdata_rd_i,
    input  wire logic [15:0] xdata_addr_i,
    input  wire logic [7:0]  xdata_wdata_i,
    output logic             xdata_to_latch_o,
    output logic      [7:0]  latch_rdata_o,
    input  wire logic        par_wr_i,
    input  wire logic        par_rd_i,
    input  wire logic [7:0]  par_wdata_i,
    output logic      [7:0]  par_rdata_o,
    input  wire logic        ea_pin_i,
    output logic             ea_latched_o,
    output logic      [2:0]  security_level_o,
    output logic             exec_block_o,
    output logic             program_in_progress_o,
    output logic      [1:0]  prog_space_o
);
    localparam int AW = $clog2(EXTRA_ROW_SPACE_DEPTH);
    localparam int CW = $clog2(PROG_CNT + 1);

    logic [3:0]  launch_command_nibble_reg;
    logic        latch_space_map_reg;
    fpc_space_t  flash_space_select_reg;
    fpc_seq_t    seq_reg;
    logic [7:0]  sec_byte_reg;
    logic        copy_reg;
    logic [AW-1:0] copy_addr_reg;
    logic [1:0]  space_run_reg;
    logic        busy;
    logic        done;
    logic [CW-1:0] step;
    logic [7:0]  latch_rd_data;
    logic [7:0]  extra_row_space_rd_data;
    logic [2:0]  level;
    logic        ctl_wr;
    logic        from_ext;
    logic        launch;
    logic        latch_hit;
    logic [AW-1:0] latch_rd_addr;
    logic [AW-1:0] extra_row_space_rd_addr;
    logic [1:0]  sel_reg;
    logic [7:0]  sel_data_reg;
    logic        sel_valid_reg;

    assign ctl_wr   = sfr_wr_i && (sfr_addr_i == FLASH_CONTROL_ADDR); // RULE17
    assign from_ext = (fetch_region_i == FROM_EXTERNAL) || rollover_i;

    // security level from the lock bits, highest programmed bit wins
    always_comb begin
        if (!sec_byte_reg[LB2_POS]) begin
            level = 3'd4; // RULE15
        end else if (!sec_byte_reg[LB1_POS]) begin
            level = 3'd3; // RULE14
        end else if (!sec_byte_reg[LB0_POS]) begin
            level = 3'd2; // RULE13
        end else begin
            level = 3'd1; // RULE12
        end
    end

    // control fields; ignored while busy so a running cycle keeps its target
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            launch_command_nibble_reg <= FLASH_CONTROL_RESET[CMD_HI:CMD_LO];
            latch_space_map_reg       <= FLASH_CONTROL_RESET[MAP_BIT];
            flash_space_select_reg    <= SPACE_USER;
        end else if (ctl_wr && !busy) begin
            launch_command_nibble_reg <= sfr_wdata_i[CMD_HI:CMD_LO];
            latch_space_map_reg       <= sfr_wdata_i[MAP_BIT]; // RULE19
            flash_space_select_reg    <=
                fpc_space_t'(sfr_wdata_i[MODE_HI:MODE_LO]); // RULE10 RULE8
        end
    end

    // launch sequencer: the fire write must come in the very next instruction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            case (seq_reg)
                SEQ_IDLE: begin
                    if (ctl_wr && !busy
                        && sfr_wdata_i[CMD_HI:CMD_LO] == CMD_ARM) begin
                        seq_reg <= SEQ_ARMED; // RULE18
                    end
                end
                SEQ_ARMED: begin
                    if (ctl_wr) begin
                        seq_reg <= SEQ_IDLE;
                    end else if (instr_start_i) begin
                        seq_reg <= SEQ_WAIT;
                    end
                end
                SEQ_WAIT: begin
                    if (ctl_wr || instr_start_i) begin
                        seq_reg <= SEQ_IDLE; // RULE23
                    end
                end
                default: begin
                    seq_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // boot code only, valid space, fire nibble right after the arm write
    assign launch = ctl_wr && !busy && (seq_reg != SEQ_IDLE)
                    && sfr_wdata_i[CMD_HI:CMD_LO] == CMD_FIRE
                    && fetch_region_i == FROM_BOOT && !rollover_i
                    && sfr_wdata_i[MODE_HI:MODE_LO] != SPACE_NONE; // RULE4 RULE24 RULE20 RULE25

    fpc_prog_timer #(
        .CYCLES (PROG_CNT),
        .CW     (CW)
    ) u_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (launch),
        .busy_o  (busy),
        .done_o  (done),
        .step_o  (step)
    );

    // remember the target space of the running cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            space_run_reg <= SPACE_USER;
        end else if (launch) begin
            space_run_reg <= sfr_wdata_i[MODE_HI:MODE_LO];
        end
    end

    // copy pass: first steps read the latch, a cycle later write the target
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            copy_reg      <= 1'b0;
            copy_addr_reg <= '0;
        end else begin
            copy_reg      <= busy && step < CW'(EXTRA_ROW_SPACE_DEPTH);
            copy_addr_reg <= step[AW-1:0];
        end
    end

    // lock bits only change through the parallel port, and only at level one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec_byte_reg <= SEC_BYTE_RESET; // RULE11
        end else if (par_wr_i && level == 3'd1) begin
            sec_byte_reg <= par_wdata_i; // RULE13
        end else if (copy_reg && space_run_reg == SPACE_SECURITY
                     && copy_addr_reg == LATCH_SEC[AW-1:0]) begin
            sec_byte_reg <= (latch_rd_data & ~LOCK_MASK)
                            | (sec_byte_reg & LOCK_MASK); // RULE11 RULE4
        end
    end

    // xdata reaches the latch only with the map bit and internal code
    assign latch_hit = latch_space_map_reg && !from_ext; // RULE19 RULE21
    assign latch_rd_addr = copy_reg || busy ? step[AW-1:0]
                                            : xdata_addr_i[AW-1:0];

    fpc_byte_mem #(
        .DEPTH (EXTRA_ROW_SPACE_DEPTH),
        .WIDTH (8)
    ) u_latch (
        .clk_i     (clk_i),
        .wr_en_i   (xdata_wr_i && latch_hit && !busy), // RULE3 RULE19
        .wr_addr_i (xdata_addr_i[AW-1:0]),
        .wr_data_i (xdata_wdata_i),
        .rd_addr_i (latch_rd_addr),
        .rd_data_o (latch_rd_data)
    );

    assign extra_row_space_rd_addr = code_data_pointer_i[AW-1:0];

    fpc_byte_mem #(
        .DEPTH (EXTRA_ROW_SPACE_DEPTH),
        .WIDTH (8)
    ) u_extra_row_space (
        .clk_i     (clk_i),
        .wr_en_i   (copy_reg && space_run_reg == SPACE_EXTRA_ROW_SPACE), // RULE20
        .wr_addr_i (copy_addr_reg),
        .wr_data_i (latch_rd_data),
        .rd_addr_i (extra_row_space_rd_addr),
        .rd_data_o (extra_row_space_rd_data)
    );

    // xdata routing flag one cycle after the access, latch read data two cycles after it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xdata_to_latch_o <= 1'b0;
            latch_rdata_o    <= 8'h00;
        end else begin
            xdata_to_latch_o <= (xdata_wr_i || xdata_rd_i) && latch_hit;
            latch_rdata_o    <= latch_rd_data;
        end
    end

    // code read stage one: pick the source; 1 extra_row_space, 2 direct byte (user, security or barred)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg       <= 2'd0;
            sel_data_reg  <= 8'h00;
            sel_valid_reg <= 1'b0;
        end else begin
            sel_valid_reg <= code_rd_i;
            sel_reg       <= 2'd2;
            sel_data_reg  <= user_byte_i;
            if (from_ext && (level > 3'd1
                || flash_space_select_reg != SPACE_USER)) begin
                sel_data_reg <= BARRED_BYTE; // RULE13 RULE21
            end else if (flash_space_select_reg == SPACE_EXTRA_ROW_SPACE
                         && code_acc_i == 8'h00
                         && code_data_pointer_i >= EXTRA_ROW_SPACE_BASE) begin
                sel_reg <= 2'd1; // RULE7
            end else if (flash_space_select_reg == SPACE_SECURITY
                         && code_acc_i == 8'h00
                         && code_data_pointer_i == SEC_ADDR) begin
                sel_data_reg <= sec_byte_reg; // RULE9 RULE10
            end else begin
                sel_data_reg <= user_byte_i; // RULE12 RULE8
            end
        end
    end

    // code read stage two: registered answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_rdata_o <= 8'h00;
            code_valid_o <= 1'b0;
        end else begin
            code_valid_o <= sel_valid_reg;
            code_rdata_o <= sel_reg == 2'd1 ? extra_row_space_rd_data : sel_data_reg;
        end
    end

    // parallel verify is blanked from level three upward
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            par_rdata_o <= 8'h00;
        end else if (par_rd_i) begin
            par_rdata_o <= level >= 3'd3 ? BARRED_BYTE : sec_byte_reg; // RULE14
        end
    end

    // access pin captured while reset is held, kept from level two up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ea_latched_o <= ea_pin_i; // RULE13
        end else if (level == 3'd1) begin
            ea_latched_o <= ea_pin_i;
        end
    end

    // status outputs and register readback
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sfr_rdata_o           <= 8'h00;
            security_level_o      <= 3'd4;
            exec_block_o          <= 1'b0;
            program_in_progress_o <= 1'b0;
            prog_space_o          <= SPACE_USER;
        end else begin
            if (sfr_rd_i && sfr_addr_i == FLASH_CONTROL_ADDR) begin
                sfr_rdata_o <= {launch_command_nibble_reg,
                                latch_space_map_reg,
                                flash_space_select_reg, busy}; // RULE17 RULE5
            end
            security_level_o      <= level;
            exec_block_o          <= rollover_i && level == 3'd4; // RULE15
            program_in_progress_o <= busy || launch; // RULE22 RULE5
            prog_space_o          <= launch ? sfr_wdata_i[MODE_HI:MODE_LO]
                                            : space_run_reg;
        end
    end

    // checks
    AST_LAUNCH_BUSY: assert property (@(posedge clk_i) disable iff (rst_i)
        launch |=> program_in_progress_o && busy) // RULE22
        else $error("busy not raised after launch");
    AST_BUSY_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
        launch |=> busy [*8]) // RULE22
        else $error("busy dropped early");
    AST_BUSY_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
        done |-> !busy ##1 !program_in_progress_o) // RULE5
        else $error("busy stuck after done");
    AST_LONE_FIRE: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_reg == SEQ_IDLE && !busy && ctl_wr) |=> !busy) // RULE25
        else $error("lone fire write started programming");
    AST_BOOT_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctl_wr && fetch_region_i != FROM_BOOT) |-> !launch) // RULE4
        else $error("launch from non boot code");
    AST_GAP_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
        (seq_reg == SEQ_WAIT && instr_start_i && !ctl_wr)
        |=> seq_reg == SEQ_IDLE) // RULE23
        else $error("sequence not aborted");
    AST_SEC_READ: assert property (@(posedge clk_i) disable iff (rst_i)
        (code_rd_i && !from_ext && flash_space_select_reg == SPACE_SECURITY
         && code_acc_i == 8'h00 && code_data_pointer_i == SEC_ADDR && !par_wr_i
         && !copy_reg)
        |-> ##2 code_valid_o && code_rdata_o == $past(sec_byte_reg, 2)) // RULE9
        else $error("security byte read wrong");
    AST_EXT_BARRED: assert property (@(posedge clk_i) disable iff (rst_i)
        (code_rd_i && from_ext && level > 3'd1)
        |-> ##2 code_rdata_o == BARRED_BYTE) // RULE13
        else $error("external read not barred");
    AST_LOCK_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
        !par_wr_i |=> (sec_byte_reg & LOCK_MASK)
                      == ($past(sec_byte_reg) & LOCK_MASK)) // RULE11
        else $error("lock bits changed without parallel write");
    AST_ROLL_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        (rollover_i && level == 3'd4) |=> exec_block_o) // RULE15
        else $error("rollover not blocked");
    AST_PAR_VERIFY: assert property (@(posedge clk_i) disable iff (rst_i)
        (par_rd_i && level >= 3'd3) |=> par_rdata_o == BARRED_BYTE) // RULE14
        else $error("verify not blocked");
    COV_LAUNCH_USER: cover property (@(posedge clk_i)
        launch && sfr_wdata_i[MODE_HI:MODE_LO] == SPACE_USER);
    COV_LAUNCH_SEC: cover property (@(posedge clk_i)
        launch && sfr_wdata_i[MODE_HI:MODE_LO] == SPACE_SECURITY);
    COV_EXTRA_ROW_SPACE_READ: cover property (@(posedge clk_i)
        code_rd_i && flash_space_select_reg == SPACE_EXTRA_ROW_SPACE);
    COV_ABORT: cover property (@(posedge clk_i)
        seq_reg == SEQ_WAIT ##1 seq_reg == SEQ_IDLE);
endmodule
`default_nettype wire

// ===== bench/fpc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// cpu core side: register writes, instruction starts and code reads
module fpc_cpu_model (
    input  wire logic        clk_i,
    output logic      [7:0]  addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [7:0]  wdata_o,
    output logic             start_o,
    output logic      [1:0]  region_o,
    output logic             crd_o,
    output logic      [15:0] data_pointer_o
);
    // quiet bus at time zero, code running from boot flash
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
        start_o = 1'b0;
        region_o = 2'b01;
        crd_o = 1'b0;
        data_pointer_o = 16'h0000;
    end
    // data goes stale after the strobe so nothing leans on it
    task automatic wr(input logic [7:0] d);
        @(negedge clk_i);
        addr_o = 8'hd1;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd();
        @(negedge clk_i);
        addr_o = 8'hd1;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic region(input logic [1:0] r);
        @(negedge clk_i);
        region_o = r;
    endtask
    // no interrupts exist here, so nothing splits the pair
    // extra instruction starts between the writes break the pair
    task automatic launch(input logic [3:0] lo, input int extra);
        wr({4'h5, lo});
        repeat (extra + 1) begin
            start_o = 1'b1;
            @(negedge clk_i);
            start_o = 1'b0;
            @(negedge clk_i);
        end
        wr({4'ha, lo});
    endtask
    // indexed code read; returns while the one-cycle valid pulse stands
    task automatic cread(input logic [15:0] p);
        @(negedge clk_i);
        data_pointer_o = p;
        crd_o = 1'b1;
        @(negedge clk_i);
        crd_o = 1'b0;
        repeat (1) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== bench/fpc_flash_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_control_test;
    import fpc_pkg::*;
    localparam int PCNT = 130; // short programming, still above latch depth
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr, wdata, rdata, cdata, pdata, d, lrd;
    logic [7:0]  acc, ubyte, xwd, pwd;
    logic [15:0] data_pointer, xaddr;
    logic [1:0]  region, space;
    logic [2:0]  lvl;
    logic        wr, rd, start, crd, cvalid, tolatch, eal, xblk, busy;
    logic        xwr, xrd, pwr, prd, roll, ea;
    logic [31:0] seed = 32'h33;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    logic [7:0]  xr [4];
    logic [6:0]  xo [4];
    always #2.5 clk_i = ~clk_i;
    fpc_cpu_model u_fpc_cpu_model (.clk_i(clk_i), .addr_o(addr), .wr_o(wr),
        .rd_o(rd), .wdata_o(wdata), .start_o(start), .region_o(region),
        .crd_o(crd), .data_pointer_o(data_pointer));
    fpc_flash_control #(.PROG_CNT(PCNT)) u_fpc_flash_control (
        .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .instr_start_i(start), .fetch_region_i(region), .rollover_i(roll),
        .code_rd_i(crd), .code_acc_i(acc), .code_data_pointer_i(data_pointer),
        .user_byte_i(ubyte), .code_rdata_o(cdata), .code_valid_o(cvalid),
        .xdata_wr_i(xwr), .xdata_rd_i(xrd), .xdata_addr_i(xaddr),
        .xdata_wdata_i(xwd), .xdata_to_latch_o(tolatch), .latch_rdata_o(lrd),
        .par_wr_i(pwr), .par_rd_i(prd), .par_wdata_i(pwd),
        .par_rdata_o(pdata), .ea_pin_i(ea), .ea_latched_o(eal),
        .security_level_o(lvl), .exec_block_o(xblk),
        .program_in_progress_o(busy), .prog_space_o(space));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(input string n, input logic [15:0] s, e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // a cut-short run still ends in the closing report
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic xw(input logic [15:0] a, input logic [7:0] v,
                      input logic e);
        @(negedge clk_i);
        xaddr = a;
        xwd = v;
        xwr = 1'b1;
        @(negedge clk_i);
        xwr = 1'b0;
        xwd = ~v;
        check("to_latch", tolatch, e);
    endtask
    task automatic cchk(input logic [15:0] p, input logic [7:0] e);
        u_fpc_cpu_model.cread(p);
        check("code_valid", cvalid, 1'b1);
        check("code_data", cdata, e);
    endtask
    // busy must stand about the programming time, then drop
    task automatic pwait(input logic on);
        int n;
        n = 0;
        @(negedge clk_i);
        check("busy", busy, on);
        while (busy === 1'b1 && n < PCNT + 10) begin
            @(negedge clk_i);
            n++;
        end
        if (on) check("prog_len", n >= PCNT - 3, 1'b1);
        check("busy_end", busy, 1'b0);
    endtask
    // levels two and three are never programmed from here
    initial begin
        // inputs quiet while reset is held
        {acc, ubyte, xwd, pwd, xaddr} = '0;
        {xwr, xrd, pwr, prd, roll, ea} = '0;
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        u_fpc_cpu_model.rd();
        check("ctrl", rdata, 8'h00);
        check("level", lvl, 3'h4);
        u_fpc_cpu_model.wr(8'h0b);
        u_fpc_cpu_model.rd();
        check("ctrl", rdata, 8'h0a);
        for (int i = 0; i < 4; i++) begin
            xo[i] = {i[1:0], 5'(rnd())}; // offsets kept distinct
            xr[i] = rnd();
            xw({9'h1ff, xo[i]}, xr[i], 1'b1);
        end
        // read back the last latch byte over xdata
        xrd = 1'b1;
        @(negedge clk_i);
        xrd = 1'b0;
        check("to_latch", tolatch, 1'b1);
        @(negedge clk_i);
        check("latch_rd", lrd, xr[3]);
        u_fpc_cpu_model.launch(4'ha, 0);
        pwait(1'b1);
        check("space", space, SPACE_EXTRA_ROW_SPACE);
        u_fpc_cpu_model.wr(8'h02);
        xw(16'h0000, rnd(), 1'b0);
        for (int i = 0; i < 4; i++)
            cchk({9'h1ff, xo[i]}, xr[i]);
        acc = 8'h01; // nonzero index falls back to user space
        cchk(16'hff80, ubyte);
        acc = 8'h00;
        d = rnd();
        u_fpc_cpu_model.wr(8'h0c);
        xw(16'h0000, d, 1'b1);
        u_fpc_cpu_model.launch(4'h4, 0);
        pwait(1'b1);
        u_fpc_cpu_model.wr(8'h04);
        cchk(16'h0000, {d[7:3], SEC_BYTE_RESET[2:0]});
        check("level", lvl, 3'h4);
        u_fpc_cpu_model.wr(8'h00);
        ubyte = rnd();
        cchk(16'h0000, ubyte);
        u_fpc_cpu_model.launch(4'h0, 0);
        pwait(1'b1);
        check("space", space, SPACE_USER);
        u_fpc_cpu_model.launch(4'h0, 1);
        pwait(1'b0);
        u_fpc_cpu_model.wr(8'ha0);
        pwait(1'b0);
        u_fpc_cpu_model.launch(4'h6, 0);
        pwait(1'b0);
        u_fpc_cpu_model.region(2'b00);
        u_fpc_cpu_model.launch(4'h0, 0);
        pwait(1'b0);
        u_fpc_cpu_model.region(2'b11);
        cchk(16'h0010, BARRED_BYTE);
        u_fpc_cpu_model.wr(8'h08);
        xw(16'h0001, rnd(), 1'b0);
        u_fpc_cpu_model.region(2'b01);
        roll = 1'b1;
        cchk(16'h0010, BARRED_BYTE);
        check("exec_block", xblk, 1'b1);
        roll = 1'b0;
        @(negedge clk_i);
        pwd = 8'h00;
        pwr = 1'b1;
        prd = 1'b1;
        ea = 1'b1;
        @(negedge clk_i);
        pwr = 1'b0;
        prd = 1'b0;
        @(negedge clk_i);
        check("par_verify", pdata, BARRED_BYTE);
        check("ea_latched", eal, 1'b0);
        check("level", lvl, 3'h4);
        summarize();
    end
endmodule
`default_nettype wire
